// [burst_sram_pkg.sv]
// constants, types and latency lookup for the burst sram sequencer
// ----------------------------------------------------------------------------
// Function
// [R1] first read data from a pipelined sram is expected one link cycle later than flow-through.
// [R2] attached srams must be single-cycle deselect parts, slower parts are not covered.
// [R3] the optional late-clocking data latch strobes of the sram are never driven.
// [R4] the srams run strobeless, so every sample relies on plain synchronous timing.
// [R5] the reused sleep pin acts as address strobe in the first clock of each chip select only.
// [R6] each burst spends one cycle on row select and one cycle on each of beats a to d.
// [R7] a write burst is followed by one deselect cycle, a read burst is not.
// [R8] back-to-back reads, writes and read-write-read four-beat bursts are supported.
// [R9] private memory accesses use exactly the same pin sequence as cache accesses.
// [R10] the three-stage sram gets one extra wait state before its first read beat.
// [R11] the three-stage timing is chosen by its own cache control setting.
// [R12] chip select stays high across a burst and drops between bursts.
// ----------------------------------------------------------------------------
package burst_sram_pkg;

    localparam int ADDR_W = 18;
    localparam int DATA_W = 64;
    localparam int BEATS  = 4;

    localparam logic [1:0] LAST_BEAT  = 2'h3;
    localparam logic [1:0] FIRST_BEAT = 2'h0;

    // cache control sram type setting
    localparam logic [1:0] TYPE_FLOW_THROUGH      = 2'h0;
    localparam logic [1:0] TYPE_TWO_STAGE_BURST   = 2'h1;
    localparam logic [1:0] TYPE_THREE_STAGE_BURST = 2'h2;

    // link cycles from column issue to read data sample
    localparam logic [1:0] LAT_FLOW_THROUGH = 2'h1;
    localparam logic [1:0] LAT_TWO_STAGE    = 2'h2;
    localparam logic [1:0] LAT_THREE_STAGE  = 2'h3;

    localparam int PEND_W = 4;

    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_ROW   = 2'b01,
        SEQ_COL   = 2'b11,
        SEQ_DESEL = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic                          write;
        logic                          private_mem;
        logic [ADDR_W-1:0]             addr;
        logic [BEATS-1:0][DATA_W-1:0]  data;
    } burst_req_t;

    typedef struct packed {
        logic              chip_select;
        logic              address_strobe;
        logic              write_enable;
        logic [ADDR_W-1:0] addr;
    } sram_pins_t;

    // latency lookup, unknown setting treated as slowest
    function automatic logic [1:0] read_latency(input logic [1:0] sram_type);
        logic [1:0] lat;
        lat = LAT_THREE_STAGE;
        unique case (sram_type)
            TYPE_FLOW_THROUGH:      lat = LAT_FLOW_THROUGH;
            TYPE_TWO_STAGE_BURST:   lat = LAT_TWO_STAGE;
            TYPE_THREE_STAGE_BURST: lat = LAT_THREE_STAGE;
            default:                lat = LAT_THREE_STAGE;
        endcase
        return lat;
    endfunction

endpackage

// [pipelined_burst_sram_seq.sv]
// burst sram sequencer with link clock sampling and two-entry read buffer
`timescale 1ns/1ns
module pipelined_burst_sram_seq (
    input  wire logic                         sys_clk,
    input  wire logic                         sys_rst,
    input  wire logic [1:0]                   cache_ctrl_sram_type,
    input  wire logic                         req_valid,
    input  wire burst_sram_pkg::burst_req_t   req,
    output logic                              req_ready,
    output logic                              rd_valid,
    output logic [burst_sram_pkg::DATA_W-1:0] rd_data,
    input  wire logic                         rd_ready,
    input  wire logic                         sram_clk,
    output burst_sram_pkg::sram_pins_t        sram_pins,
    input  wire logic [burst_sram_pkg::DATA_W-1:0] sram_data_in,
    output logic [burst_sram_pkg::DATA_W-1:0] sram_data_out,
    output logic                              sram_data_oe,
    output logic                              sram_latch_strobe_oe
);
    import burst_sram_pkg::*;

    // ------------------------------------------------------------------
    // link clock and data sampling
    // ------------------------------------------------------------------
    logic              clk_s1_reg;
    logic              clk_s2_reg;
    logic              clk_s3_reg;
    logic [DATA_W-1:0] din_s1_reg;
    logic [DATA_W-1:0] din_s2_reg;
    logic              link_edge;

    // two-flop sync of clock and data, strobeless sampling [R4]
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_s1_reg <= 1'b0;
            clk_s2_reg <= 1'b0;
            clk_s3_reg <= 1'b0;
            din_s1_reg <= '0;
            din_s2_reg <= '0;
        end else begin
            clk_s1_reg <= sram_clk;
            clk_s2_reg <= clk_s1_reg;
            clk_s3_reg <= clk_s2_reg;
            din_s1_reg <= sram_data_in;
            din_s2_reg <= din_s1_reg;
        end
    end

    assign link_edge = clk_s2_reg & ~clk_s3_reg;

    // ------------------------------------------------------------------
    // request holding
    // ------------------------------------------------------------------
    seq_state_t        state_reg;
    logic [1:0]        beat_reg;
    logic [1:0]        lat_reg;
    logic [PEND_W-1:0] pend_reg;
    logic              skid_v_reg;
    logic              hold_v_reg;
    logic              hold_v_next;
    logic              req_ready_reg;
    burst_req_t        hold_reg;
    burst_req_t        cur_reg;
    logic              capture_due;
    logic              step;
    logic              start;

    // a due read beat with a full buffer freezes the sequence
    assign capture_due = link_edge & pend_reg[0];
    assign step        = link_edge & ~(pend_reg[0] & skid_v_reg);
    // writes wait until the data bus carries no read beat [R8]
    assign start       = step && (state_reg == SEQ_IDLE) && hold_v_reg &&
                         (!hold_reg.write || (pend_reg == '0));

    always_comb begin
        hold_v_next = hold_v_reg;
        if (req_valid && req_ready_reg) begin
            hold_v_next = 1'b1;
        end else if (start) begin
            hold_v_next = 1'b0;
        end
    end

    // one request held ahead of the sequencer
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_v_reg    <= 1'b0;
            req_ready_reg <= 1'b0;
            hold_reg      <= '0;
        end else begin
            hold_v_reg    <= hold_v_next;
            req_ready_reg <= ~hold_v_next;
            if (req_valid && req_ready_reg) begin
                hold_reg <= req;
            end
        end
    end

    // ------------------------------------------------------------------
    // burst sequencer
    // ------------------------------------------------------------------
    sram_pins_t        pins_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic              oe_reg;
    logic              strobe_oe_reg;
    logic              col_issue;
    logic [PEND_W-1:0] pend_ins;

    assign col_issue = step && !cur_reg.write &&
                       ((state_reg == SEQ_ROW) ||
                        (state_reg == SEQ_COL && beat_reg != LAST_BEAT));

    // read beat marker placed at the configured latency [R1] [R10]
    always_comb begin
        pend_ins = '0;
        if (col_issue) begin
            // marker falls due lat_reg steps after issue, not one more
            pend_ins[lat_reg - 2'h1] = 1'b1;  // R10
        end
    end

    // state, pins and beat count advance on each link step
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= SEQ_IDLE;
            beat_reg  <= FIRST_BEAT;
            lat_reg   <= LAT_THREE_STAGE;
            cur_reg   <= '0;
            pins_reg  <= '0;
            wdata_reg <= '0;
            oe_reg    <= 1'b0;
        end else if (step) begin
            unique case (state_reg)
                SEQ_IDLE: begin
                    if (start) begin
                        // private memory takes the same path unchanged [R9]
                        cur_reg                 <= hold_reg;
                        lat_reg                 <= read_latency(cache_ctrl_sram_type); // R11
                        state_reg               <= SEQ_ROW;
                        pins_reg.chip_select    <= 1'b1;  // R12
                        pins_reg.address_strobe <= 1'b1;  // R5
                        pins_reg.write_enable   <= hold_reg.write;
                        pins_reg.addr           <= hold_reg.addr;
                    end
                end
                SEQ_ROW: begin
                    // row select done, column a next [R6]
                    state_reg               <= SEQ_COL;
                    beat_reg                <= FIRST_BEAT;
                    pins_reg.address_strobe <= 1'b0;  // R5
                    wdata_reg               <= cur_reg.data[FIRST_BEAT];
                    oe_reg                  <= cur_reg.write;
                end
                SEQ_COL: begin
                    if (beat_reg == LAST_BEAT) begin
                        pins_reg.chip_select  <= 1'b0;  // R12
                        pins_reg.write_enable <= 1'b0;
                        oe_reg                <= 1'b0;
                        // only writes pay the deselect cycle [R7]
                        state_reg <= cur_reg.write ? SEQ_DESEL : SEQ_IDLE;
                    end else begin
                        beat_reg  <= beat_reg + 2'h1;  // R6
                        wdata_reg <= cur_reg.data[beat_reg + 2'h1];
                    end
                end
                SEQ_DESEL: begin
                    state_reg <= SEQ_IDLE;  // R7
                end
            endcase
        end
    end

    // pending read beats, shifted once per link step
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_reg <= '0;
        end else if (step) begin
            pend_reg <= (pend_reg >> 1) | pend_ins;
        end
    end

    // late-clocking latch strobes stay undriven [R3]
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            strobe_oe_reg <= 1'b0;
        end else begin
            strobe_oe_reg <= 1'b0;  // R3
        end
    end

    // ------------------------------------------------------------------
    // two-entry read buffer
    // ------------------------------------------------------------------
    logic              out_v_reg;
    logic [DATA_W-1:0] out_data_reg;
    logic [DATA_W-1:0] skid_data_reg;
    logic              push;
    logic              pop;

    assign push = capture_due & ~skid_v_reg;
    assign pop  = out_v_reg & rd_ready;

    // output stage plus skid stage, a due read beat with a full skid stalls the sequencer
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_v_reg     <= 1'b0;
            skid_v_reg    <= 1'b0;
            out_data_reg  <= '0;
            skid_data_reg <= '0;
        end else if (pop) begin
            if (skid_v_reg) begin
                out_data_reg <= skid_data_reg;
                skid_v_reg   <= 1'b0;
            end else if (push) begin
                out_data_reg <= din_s2_reg;
            end else begin
                out_v_reg <= 1'b0;
            end
        end else if (push) begin
            if (!out_v_reg) begin
                out_data_reg <= din_s2_reg;
                out_v_reg    <= 1'b1;
            end else begin
                skid_data_reg <= din_s2_reg;
                skid_v_reg    <= 1'b1;
            end
        end
    end

    assign req_ready            = req_ready_reg;
    assign rd_valid             = out_v_reg;
    assign rd_data              = out_data_reg;
    assign sram_pins            = pins_reg;
    assign sram_data_out        = wdata_reg;
    assign sram_data_oe         = oe_reg;
    assign sram_latch_strobe_oe = strobe_oe_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_strobe_first_clock: assert property (  // R5
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(pins_reg.chip_select) |-> pins_reg.address_strobe)
        else $error("address strobe missing in first select clock");

    chk_strobe_one_step: assert property (  // R5
        @(posedge sys_clk) disable iff (sys_rst)
        (step && pins_reg.address_strobe) |=> !pins_reg.address_strobe)
        else $error("address strobe held past first clock");

    chk_strobe_needs_select: assert property (  // R5
        @(posedge sys_clk) disable iff (sys_rst)
        pins_reg.address_strobe |-> pins_reg.chip_select && state_reg == SEQ_ROW)
        else $error("address strobe outside first select clock");

    chk_select_held_burst: assert property (  // R12
        @(posedge sys_clk) disable iff (sys_rst)
        (state_reg == SEQ_ROW || state_reg == SEQ_COL) |-> pins_reg.chip_select)
        else $error("chip select dropped inside burst");

    chk_four_columns: assert property (  // R6
        @(posedge sys_clk) disable iff (sys_rst)
        $fell(pins_reg.chip_select) |-> $past(state_reg) == SEQ_COL &&
        $past(beat_reg) == LAST_BEAT)
        else $error("burst ended without four columns");

    chk_write_deselect: assert property (  // R7
        @(posedge sys_clk) disable iff (sys_rst)
        (step && state_reg == SEQ_COL && beat_reg == LAST_BEAT && cur_reg.write)
        |=> state_reg == SEQ_DESEL)
        else $error("write burst missed deselect cycle");

    chk_read_no_deselect: assert property (  // R7
        @(posedge sys_clk) disable iff (sys_rst)
        (step && state_reg == SEQ_COL && beat_reg == LAST_BEAT && !cur_reg.write)
        |=> state_reg == SEQ_IDLE)
        else $error("read burst took a deselect cycle");

    chk_read_latency: assert property (  // R1 R10
        @(posedge sys_clk) disable iff (sys_rst)
        (step && state_reg == SEQ_ROW && !cur_reg.write && lat_reg == LAT_THREE_STAGE)
        |=> pend_reg[2] && !pend_reg[1] && !pend_reg[3])
        else $error("three-stage first beat latency wrong");

    chk_type_select: assert property (  // R11
        @(posedge sys_clk) disable iff (sys_rst)
        start |=> lat_reg == read_latency($past(cache_ctrl_sram_type)))
        else $error("latency not taken from sram type setting");

    chk_bus_turnaround: assert property (  // R8
        @(posedge sys_clk) disable iff (sys_rst)
        oe_reg |-> pend_reg == '0 && pins_reg.write_enable)
        else $error("write data driven while read beats pending");

    chk_no_latch_strobe: assert property (  // R3
        @(posedge sys_clk) disable iff (sys_rst)
        !sram_latch_strobe_oe)
        else $error("latch strobe driven");

    cov_read_burst: cover property (
        @(posedge sys_clk) disable iff (sys_rst)
        start && !hold_reg.write);

    cov_write_burst: cover property (
        @(posedge sys_clk) disable iff (sys_rst)
        step && state_reg == SEQ_DESEL);

    cov_private_burst: cover property (
        @(posedge sys_clk) disable iff (sys_rst)
        start && hold_reg.private_mem);

    cov_buffer_stall: cover property (
        @(posedge sys_clk) disable iff (sys_rst)
        capture_due && skid_v_reg);

endmodule

// [sram_model.sv]
// behavioural burst sram on the link side, output depth set by sram type
`timescale 1ns/1ns
module sram_model (
    input  wire logic                              sram_clk,
    input  wire logic [1:0]                        sram_type,
    input  wire burst_sram_pkg::sram_pins_t        pins,
    input  wire logic [burst_sram_pkg::DATA_W-1:0] din,
    input  wire logic                              din_oe,
    output logic [burst_sram_pkg::DATA_W-1:0]      dout
);
    import burst_sram_pkg::*;
    logic [DATA_W-1:0] mem [logic [ADDR_W+1:0]];
    logic [ADDR_W-1:0] base_reg;
    logic [2:0]        beat_reg;
    logic              we_reg;
    logic [DATA_W-1:0] p1_reg;
    logic [DATA_W-1:0] p2_reg;
    logic              v1_reg;
    logic              v2_reg;
    logic [DATA_W-1:0] rd_word;
    logic              rd_now;

    initial begin
        beat_reg = 3'h4;
        we_reg = 1'b0;
        v1_reg = 1'b0;
        v2_reg = 1'b0;
        dout = '0;
    end

    // ------------------------------------------------------------------
    // array access
    // ------------------------------------------------------------------
    // row on strobe, one column per clock, deselect as soon as select drops
    always @(posedge sram_clk) begin
        rd_now = 1'b0;
        rd_word = '0;
        v1_reg <= 1'b0;
        v2_reg <= v1_reg;
        p2_reg <= p1_reg;
        if (pins.chip_select !== 1'b1) begin
            beat_reg <= 3'h4;
        end else if (pins.address_strobe) begin
            base_reg <= pins.addr;
            we_reg <= pins.write_enable;
            beat_reg <= 3'h0;
        end else if (beat_reg < 3'h4) begin
            if (we_reg && din_oe) begin
                mem[{base_reg, beat_reg[1:0]}] = din;
            end else if (!we_reg) begin
                rd_word = mem.exists({base_reg, beat_reg[1:0]}) ?
                          mem[{base_reg, beat_reg[1:0]}] : '0;
                rd_now = 1'b1;
                p1_reg <= rd_word;
                v1_reg <= 1'b1;
            end
            beat_reg <= beat_reg + 3'h1;
        end
        // output depth follows the sram type, bus toggles when nothing is driven
        if (sram_type == TYPE_FLOW_THROUGH) begin
            dout <= rd_now ? rd_word : ~dout;
        end else if (sram_type == TYPE_TWO_STAGE_BURST) begin
            dout <= v1_reg ? p1_reg : ~dout;
        end else begin
            dout <= v2_reg ? p2_reg : ~dout;
        end
    end
endmodule

// [tb_top.sv]
// self-checking bench for the pipelined burst sram sequencer
`timescale 1ns/1ns
module tb_top;
    import burst_sram_pkg::*;
    logic              sys_clk, sys_rst, sram_clk, req_valid, req_ready;
    logic              rd_valid, rd_ready, sram_data_oe, latch_oe, cs_q;
    logic [1:0]        sram_type;
    burst_req_t        req;
    sram_pins_t        pins;
    logic [DATA_W-1:0] rd_data, sram_din, sram_dout;
    logic [DATA_W-1:0] rx_q[$];
    int                err_count, cmp_count, ads_bad, lo_cnt, hi_cnt;
    int                gap_q[$], len_q[$];

    initial begin sys_clk = 1'b0; forever #5 sys_clk = ~sys_clk; end
    initial begin sram_clk = 1'b0; #3; forever #80 sram_clk = ~sram_clk; end

    pipelined_burst_sram_seq dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .cache_ctrl_sram_type(sram_type), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready),
        .sram_clk(sram_clk), .sram_pins(pins), .sram_data_in(sram_din),
        .sram_data_out(sram_dout), .sram_data_oe(sram_data_oe),
        .sram_latch_strobe_oe(latch_oe));
    sram_model mem (.sram_clk(sram_clk), .sram_type(sram_type), .pins(pins), .din(sram_dout),
        .din_oe(sram_data_oe), .dout(sram_din));

    // select length, gap and strobe placement seen by the sram
    always @(posedge sram_clk) begin
        if (pins.chip_select === 1'b1) begin
            if (!cs_q) begin gap_q.push_back(lo_cnt); hi_cnt = 0; end
            if (pins.address_strobe !== !cs_q) ads_bad++;
            hi_cnt++;
        end else begin
            if (cs_q) begin len_q.push_back(hi_cnt); lo_cnt = 0; end
            lo_cnt++;
        end
        cs_q = (pins.chip_select === 1'b1);
    end

    // read beat collector
    always @(posedge sys_clk) if (rd_valid === 1'b1 && rd_ready === 1'b1) rx_q.push_back(rd_data);

    function automatic logic [DATA_W-1:0] word(input logic [17:0] a, input logic [1:0] b);
        return {8'ha5, a, 36'h0, b};
    endfunction

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic timed_out();
        chk(64'h0, 64'h1);
        give_verdict();
    endtask

    // one burst request held until taken
    task automatic send(input logic wr, input logic pm, input logic [17:0] a);
        int n;
        n = 0;
        req.write <= wr;
        req.private_mem <= pm;
        req.addr <= a;
        for (int b = 0; b < BEATS; b++) req.data[b] <= word(a, b[1:0]);
        req_valid <= 1'b1;
        do begin @(posedge sys_clk); n++; end while (req_ready !== 1'b1 && n < 3000);
        if (n >= 3000) timed_out();
        req_valid <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wait_idle();
        int n, c;
        n = 0;
        c = 0;
        while (c < 48) begin
            @(posedge sys_clk);
            c = (pins.chip_select === 1'b0 && req_ready === 1'b1) ? c + 1 : 0;
            if (++n > 5000) timed_out();
        end
    endtask

    task automatic wait_rx(input int k);
        int n;
        n = 0;
        while (rx_q.size() < k) begin @(posedge sys_clk); if (++n > 5000) timed_out(); end
    endtask

    task automatic clear();
        gap_q.delete();
        len_q.delete();
        rx_q.delete();
        ads_bad = 0;
    endtask

    task automatic chk_link(input int gap);
        foreach (len_q[i]) chk(len_q[i], 5);
        for (int i = 1; i < gap_q.size(); i++) chk(gap_q[i], gap);
        chk(ads_bad, 0);
        chk(latch_oe, 1'b0);
    endtask

    task automatic t_reset();
        chk({req_ready, rd_valid, pins.chip_select, pins.address_strobe}, 4'h0);
        chk({sram_data_oe, latch_oe}, 2'h0);
        $display("test reset done");
    endtask

    task automatic t_writes(input logic [17:0] a, input logic pm);
        clear();
        for (int i = 0; i < 3; i++) send(1'b1, pm, a + 18'(i * 4));
        wait_idle();
        chk_link(2);
        $display("test writes done");
    endtask

    task automatic t_reads(input logic [17:0] a, input logic pm);
        clear();
        for (int i = 0; i < 3; i++) send(1'b0, pm, a + 18'(i * 4));
        wait_rx(12);
        for (int i = 0; i < 12; i++) chk(rx_q[i], word(a + 18'((i / 4) * 4), 2'(i)));
        wait_idle();
        chk_link(1);
        $display("test reads done");
    endtask

    task automatic t_rwr();
        clear();
        send(1'b0, 1'b0, 18'h004);
        send(1'b1, 1'b0, 18'h200);
        send(1'b0, 1'b0, 18'h200);
        wait_rx(8);
        for (int i = 0; i < 8; i++) chk(rx_q[i], word(i < 4 ? 18'h004 : 18'h200, 2'(i)));
        wait_idle();
        foreach (len_q[i]) chk(len_q[i], 5);
        chk(gap_q[2], 2);
        chk(ads_bad, 0);
        $display("test read write read done");
    endtask

    task automatic t_buffer();
        int n;
        n = 0;
        clear();
        rd_ready <= 1'b0;
        send(1'b0, 1'b0, 18'h008);
        while (rd_valid !== 1'b1) begin @(posedge sys_clk); if (++n > 3000) timed_out(); end
        repeat (24) @(posedge sys_clk);
        chk({rd_valid, rd_data}, {1'b1, word(18'h008, 2'h0)});
        chk(rx_q.size(), 0);
        rd_ready <= 1'b1;
        wait_rx(4);
        for (int i = 0; i < 4; i++) chk(rx_q[i], word(18'h008, 2'(i)));
        wait_idle();
        $display("test buffer done");
    endtask

    initial begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        rd_ready = 1'b1;
        req = '0;
        sram_type = TYPE_THREE_STAGE_BURST;
        cs_q = 1'b0;
        err_count = 0;
        cmp_count = 0;
        ads_bad = 0;
        lo_cnt = 0;
        hi_cnt = 0;
        repeat (4) @(posedge sys_clk);
        t_reset();
        sys_rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        t_writes(18'h000, 1'b0);
        t_reads(18'h000, 1'b0);
        t_rwr();
        t_writes(18'h100, 1'b1);
        t_reads(18'h100, 1'b1);
        sram_type <= TYPE_FLOW_THROUGH;
        t_reads(18'h000, 1'b0);
        sram_type <= TYPE_TWO_STAGE_BURST;
        t_reads(18'h100, 1'b0);
        sram_type <= TYPE_THREE_STAGE_BURST;
        t_buffer();
        give_verdict();
    end
endmodule
